// >>> common/vdcr_pkg.sv
// Constants and carrier types for the deserializer configuration register bank.
package vdcr_pkg;

    // Register window and indices.
    localparam int         NREG      = 10;
    localparam logic [7:0] ADDR_BASE = 8'h22;
    localparam int         IDX_DP    = 0;
    localparam int         IDX_RXM   = 1;
    localparam int         IDX_BIST  = 2;
    localparam int         IDX_ERR   = 3;
    localparam int         IDX_HI    = 4;
    localparam int         IDX_LO    = 5;
    localparam int         IDX_DP2   = 6;
    localparam int         IDX_FRC   = 7;
    localparam int         IDX_WB    = 8;
    localparam int         IDX_AUD   = 9;

    // Byte addresses, one per register.
    localparam logic [7:0] ADDR_DP   = 8'h22;
    localparam logic [7:0] ADDR_RXM  = 8'h23;
    localparam logic [7:0] ADDR_BIST = 8'h24;
    localparam logic [7:0] ADDR_ERR  = 8'h25;
    localparam logic [7:0] ADDR_HI   = 8'h26;
    localparam logic [7:0] ADDR_LO   = 8'h27;
    localparam logic [7:0] ADDR_DP2  = 8'h28;
    localparam logic [7:0] ADDR_FRC  = 8'h29;
    localparam logic [7:0] ADDR_WB   = 8'h2a;
    localparam logic [7:0] ADDR_AUD  = 8'h2b;

    // Values after reset, index 9 first.
    localparam logic [NREG-1:0][7:0] REG_RST = {8'h00, 8'h00, 8'h00, 8'h00, 8'h84,
                                                8'h83, 8'h00, 8'h08, 8'h10, 8'h00};
    // Host-writable bits; all others are read-only or reserved.
    localparam logic [NREG-1:0][7:0] REG_WMASK = {8'hc1, 8'hf0, 8'hff, 8'h8d, 8'hff,
                                                  8'hff, 8'h00, 8'h0f, 8'h80, 8'hdf};
    // Writable bits of the second data path register loaded from the forward channel.
    localparam logic [7:0] DP2_FC_MASK = 8'h0d;

    // Field positions.
    localparam int DP_PASS    = 6;
    localparam int DP_PVPOL   = 5;
    localparam int DP_REGEN   = 4;
    localparam int DP_CHB_OVR = 3;
    localparam int DP_18B     = 2;
    localparam int DP_TRANS   = 1;
    localparam int DP_CHB_EN  = 0;
    localparam int RXM_CSUM   = 7;
    localparam int ST_PINCFG  = 3;
    localparam int ST_OSC_LSB = 1;
    localparam int ST_EN      = 0;
    localparam int DP2_BLOCK  = 7;
    localparam int DP2_AUX    = 3;
    localparam int DP2_DIS    = 2;
    localparam int DP2_SURR   = 0;
    localparam int FRC_SYNC   = 7;
    localparam int FRC_HSPOL  = 6;
    localparam int FRC_VSPOL  = 5;
    localparam int FRC_PVPOL  = 4;
    localparam int FRC_TWO    = 3;
    localparam int FRC_ONE    = 2;
    localparam int FRC_HI2    = 1;
    localparam int FRC_HI1    = 0;
    localparam int WB_PG_LSB  = 6;
    localparam int WB_EN      = 5;
    localparam int WB_RELOAD  = 4;
    localparam int AUD_PLLOVR = 7;
    localparam int AUD_PLLOFF = 6;
    localparam int AUD_EDGE   = 0;

    // Strap and control pins, synchronised before use.
    localparam int         PIN_W       = 6;
    localparam int         PIN_LFREQ   = 0;
    localparam int         PIN_LEGACY  = 1;
    localparam int         PIN_REPEAT  = 2;
    localparam int         PIN_LANE    = 3;
    localparam int         PIN_ST      = 4;
    localparam int         PIN_PDN     = 5;
    localparam logic [5:0] PIN_RST     = 6'h00;
    localparam logic [7:0] ERR_MAX     = 8'hff;
    localparam logic [7:0] ERR_RST     = 8'h00;

    typedef struct packed {
        logic       pass_pixels;
        logic       protect_ok;
        logic       packet_audio_blocked;
        logic       audio_regen;
        logic       ch_b_en;
        logic       color_18bit;
        logic       audio_fc_transport;
        logic       checksum_en;
        logic       checksum_fail;
        logic       st_active;
        logic [1:0] osc_sel;
        logic       osc_low_rate;
        logic [7:0] scl_high;
        logic [7:0] scl_low;
        logic [7:0] slave_setup;
        logic       fc_cfg_blocked;
        logic       aux_audio_en;
        logic       audio_disable;
        logic       surround_en;
        logic       sync_timing;
        logic       line_sync_low;
        logic       frame_sync_low;
        logic       pixel_valid_low;
        logic       dither_stage_one;
        logic       dither_stage_two;
        logic       high_dither_one;
        logic       high_dither_two;
        logic [1:0] page;
        logic       white_balance_en;
        logic       lookup_table_reload;
        logic       pll_off;
        logic       sample_rising;
    } vdcr_ctrl_s;

    typedef struct packed {
        logic [NREG-1:0][7:0] regs;
        logic [2:0][PIN_W-1:0] sync;
        logic [PIN_W-1:0]      pins;
        logic                  st_prev;
        logic [7:0]            err_cnt;
        logic [7:0]            rdata;
        vdcr_ctrl_s            ctrl;
    } vdcr_state_s;

endpackage : vdcr_pkg

// >>> src/vdcr_regs.sv
// Configuration and status register bank of the serial-video deserializer.
`timescale 1ns/100ps
// Functional notes
// - Pass-pixels forwards colour regardless of pixel valid; blocks protection and packet audio.
// - Data path bit 5 reports pixel-valid polarity: 0 active high, 1 active low.
// - Regeneration bit 0 outputs packet audio on video pins; 1 regenerates serial audio.
// - Colour depth bit: 0 selects 24-bit video, 1 selects 18-bit video.
// - Transport bit: 0 data-island audio transport, 1 forward-channel frame transport.
// - Second audio channel enable comes from register only when override bit 3 set.
// - Checksum enable makes the receiver check each line checksum and report failures.
// - Low-frequency status bit follows the strap: 0 means 15-85MHz, 1 means 5-15MHz.
// - Read-only bits 2,1,0 follow repeater, legacy and second-lane straps.
// - Self-test runs from pin when pin-config bit is one, else from register enable.
// - Oscillator source codes 00 and 01 select 33 MHz, 12.5MHz in low-frequency mode.
// - Self-test error count saturates at 255, clears on power-down or new self-test.
// - Master clock high time is the programmed count of 50 ns periods, default 0x83.
// - Low time sets master clock low width and slave data setup, default 0x84.
// - With bit 7 set, forward-channel loads of the second data path register are ignored.
// - Auxiliary audio bit repurposes general pins one and zero as word select and data.
// - Audio disable bit turns off every serial audio output.
// - Surround enables multichannel with data-island transport only; repeater may override.
// - Timing bit picks pixel-valid-only or sync timing; polarity bits pick active low.
// - Dither stage enables are active high; high dither bits are active low.
// - Page field picks configuration or red, green, blue lookup table; plus enables.
// - Audio sampled on falling edge unless edge bit set; override plus off kills PLL.

module vdcr_regs (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [7:0]                reg_rdata,
    input  wire logic                 fc_cfg_wr,
    input  wire logic [7:0]           fc_cfg_data,
    input  wire logic [vdcr_pkg::PIN_W-1:0] strap_pins,
    input  wire logic                 pixel_valid_pol,
    input  wire logic                 fc_error,
    input  wire logic                 line_checksum_fail,
    input  wire logic                 inband_mode_valid,
    input  wire logic                 inband_surround,
    output logic [7:0]                self_test_err_count,
    output vdcr_pkg::vdcr_ctrl_s      ctrl
);

    vdcr_pkg::vdcr_state_s   st_ff;
    vdcr_pkg::vdcr_state_s   nxt_st;
    logic [vdcr_pkg::PIN_W-1:0] pin_filt;

    // One-hot register select; shared by the write and read paths.
    function automatic logic [vdcr_pkg::NREG-1:0] reg_sel(input logic [7:0] a);
        logic [vdcr_pkg::NREG-1:0] s;
        s = '0;
        for (int i = 0; i < vdcr_pkg::NREG; i++) begin
            s[i] = (a == (vdcr_pkg::ADDR_BASE + 8'(i)));
        end
        return s;
    endfunction : reg_sel

    // A pin change is accepted only when the second and third stages agree, which rejects
    // a single sample caught mid-transition.
    genvar gi;
    generate
        for (gi = 0; gi < vdcr_pkg::PIN_W; gi++) begin : g_pin
            assign pin_filt[gi] = (st_ff.sync[1][gi] == st_ff.sync[2][gi]) ?
                                  st_ff.sync[2][gi] : st_ff.pins[gi];
        end
    endgenerate

    always_comb begin
        logic [vdcr_pkg::NREG-1:0]       sel;
        logic [vdcr_pkg::NREG-1:0][7:0]  view;
        logic [7:0]                      dp;
        logic [7:0]                      bist;
        logic [7:0]                      dp2;
        logic [7:0]                      frc;
        logic [7:0]                      wb;
        logic [7:0]                      aud;
        logic                            act;
        logic                            start;
        sel   = reg_sel(reg_addr);
        act   = 1'b0;
        start = 1'b0;
        view  = st_ff.regs;
        dp    = st_ff.regs[vdcr_pkg::IDX_DP];
        bist  = st_ff.regs[vdcr_pkg::IDX_BIST];
        dp2   = st_ff.regs[vdcr_pkg::IDX_DP2];
        frc   = st_ff.regs[vdcr_pkg::IDX_FRC];
        wb    = st_ff.regs[vdcr_pkg::IDX_WB];
        aud   = st_ff.regs[vdcr_pkg::IDX_AUD];
        nxt_st = st_ff;

        nxt_st.sync[0] = strap_pins;
        nxt_st.sync[1] = st_ff.sync[0];
        nxt_st.sync[2] = st_ff.sync[1];
        nxt_st.pins    = pin_filt;

        // Forward-channel load comes first so that a host write in the same cycle wins.
        if (fc_cfg_wr && !dp2[vdcr_pkg::DP2_BLOCK]) begin
            nxt_st.regs[vdcr_pkg::IDX_DP2] = (dp2 & ~vdcr_pkg::DP2_FC_MASK) |
                                             (fc_cfg_data & vdcr_pkg::DP2_FC_MASK);
        end
        for (int i = 0; i < vdcr_pkg::NREG; i++) begin
            if (reg_wr && sel[i]) begin
                nxt_st.regs[i] = (st_ff.regs[i] & ~vdcr_pkg::REG_WMASK[i]) |
                                 (reg_wdata & vdcr_pkg::REG_WMASK[i]);
            end
        end

        // Self-test source and error counter.
        act   = bist[vdcr_pkg::ST_PINCFG] ? st_ff.pins[vdcr_pkg::PIN_ST] :
                                            bist[vdcr_pkg::ST_EN];
        start = act && !st_ff.st_prev;
        nxt_st.st_prev = act;
        if (!st_ff.pins[vdcr_pkg::PIN_PDN]) begin
            nxt_st.err_cnt = vdcr_pkg::ERR_RST;
        end else if (start) begin
            // An error in the start cycle is kept rather than lost to the clear.
            nxt_st.err_cnt = fc_error ? 8'h01 : vdcr_pkg::ERR_RST;
        end else if (act && fc_error && st_ff.err_cnt != vdcr_pkg::ERR_MAX) begin
            nxt_st.err_cnt = st_ff.err_cnt + 8'h01;
        end

        // Read view: status bits replace the stored copies.
        view[vdcr_pkg::IDX_DP][vdcr_pkg::DP_PVPOL] = pixel_valid_pol;
        view[vdcr_pkg::IDX_RXM][3:0] = {st_ff.pins[vdcr_pkg::PIN_LFREQ],
                                        st_ff.pins[vdcr_pkg::PIN_REPEAT],
                                        st_ff.pins[vdcr_pkg::PIN_LEGACY],
                                        st_ff.pins[vdcr_pkg::PIN_LANE]};
        view[vdcr_pkg::IDX_ERR] = st_ff.err_cnt;
        if (reg_rd) begin
            nxt_st.rdata = 8'h00;
            for (int i = 0; i < vdcr_pkg::NREG; i++) begin
                if (sel[i]) begin
                    nxt_st.rdata = view[i];
                end
            end
        end

        // Decoded controls for the datapath.
        nxt_st.ctrl.pass_pixels          = dp[vdcr_pkg::DP_PASS];
        nxt_st.ctrl.protect_ok           = !dp[vdcr_pkg::DP_PASS];
        nxt_st.ctrl.packet_audio_blocked = dp[vdcr_pkg::DP_PASS];
        nxt_st.ctrl.audio_regen          = dp[vdcr_pkg::DP_REGEN];
        nxt_st.ctrl.ch_b_en              = dp[vdcr_pkg::DP_CHB_OVR] ? dp[vdcr_pkg::DP_CHB_EN] :
                                           st_ff.pins[vdcr_pkg::PIN_LANE];
        nxt_st.ctrl.color_18bit          = dp[vdcr_pkg::DP_18B];
        nxt_st.ctrl.audio_fc_transport   = dp[vdcr_pkg::DP_TRANS];
        nxt_st.ctrl.checksum_en          = st_ff.regs[vdcr_pkg::IDX_RXM][vdcr_pkg::RXM_CSUM];
        nxt_st.ctrl.checksum_fail        = st_ff.regs[vdcr_pkg::IDX_RXM][vdcr_pkg::RXM_CSUM] &&
                                           line_checksum_fail;
        nxt_st.ctrl.st_active            = act;
        nxt_st.ctrl.osc_sel              = bist[vdcr_pkg::ST_OSC_LSB +: 2];
        nxt_st.ctrl.osc_low_rate         = st_ff.pins[vdcr_pkg::PIN_LFREQ];
        nxt_st.ctrl.scl_high             = st_ff.regs[vdcr_pkg::IDX_HI];
        nxt_st.ctrl.scl_low              = st_ff.regs[vdcr_pkg::IDX_LO];
        nxt_st.ctrl.slave_setup          = st_ff.regs[vdcr_pkg::IDX_LO];
        nxt_st.ctrl.fc_cfg_blocked       = dp2[vdcr_pkg::DP2_BLOCK];
        nxt_st.ctrl.aux_audio_en         = dp2[vdcr_pkg::DP2_AUX];
        nxt_st.ctrl.audio_disable        = dp2[vdcr_pkg::DP2_DIS];
        // Surround needs data-island transport; a repeater may follow in-band detection.
        if (st_ff.pins[vdcr_pkg::PIN_REPEAT] && inband_mode_valid) begin
            nxt_st.ctrl.surround_en = inband_surround && !dp[vdcr_pkg::DP_TRANS];
        end else begin
            nxt_st.ctrl.surround_en = dp2[vdcr_pkg::DP2_SURR] && !dp[vdcr_pkg::DP_TRANS];
        end
        nxt_st.ctrl.sync_timing          = frc[vdcr_pkg::FRC_SYNC];
        nxt_st.ctrl.line_sync_low        = frc[vdcr_pkg::FRC_HSPOL];
        nxt_st.ctrl.frame_sync_low       = frc[vdcr_pkg::FRC_VSPOL];
        nxt_st.ctrl.pixel_valid_low      = frc[vdcr_pkg::FRC_PVPOL];
        nxt_st.ctrl.dither_stage_one     = frc[vdcr_pkg::FRC_ONE];
        nxt_st.ctrl.dither_stage_two     = frc[vdcr_pkg::FRC_TWO];
        nxt_st.ctrl.high_dither_one      = !frc[vdcr_pkg::FRC_HI1];
        nxt_st.ctrl.high_dither_two      = !frc[vdcr_pkg::FRC_HI2];
        nxt_st.ctrl.page                 = wb[vdcr_pkg::WB_PG_LSB +: 2];
        nxt_st.ctrl.white_balance_en     = wb[vdcr_pkg::WB_EN];
        nxt_st.ctrl.lookup_table_reload  = wb[vdcr_pkg::WB_RELOAD];
        nxt_st.ctrl.pll_off              = aud[vdcr_pkg::AUD_PLLOVR] &&
                                           aud[vdcr_pkg::AUD_PLLOFF];
        nxt_st.ctrl.sample_rising        = aud[vdcr_pkg::AUD_EDGE];
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_ff         <= '0;
            st_ff.regs    <= vdcr_pkg::REG_RST;
            st_ff.pins    <= vdcr_pkg::PIN_RST;
            st_ff.err_cnt <= vdcr_pkg::ERR_RST;
            st_ff.ctrl.protect_ok      <= 1'b1;
            st_ff.ctrl.scl_high        <= vdcr_pkg::REG_RST[vdcr_pkg::IDX_HI];
            st_ff.ctrl.scl_low         <= vdcr_pkg::REG_RST[vdcr_pkg::IDX_LO];
            st_ff.ctrl.slave_setup     <= vdcr_pkg::REG_RST[vdcr_pkg::IDX_LO];
            st_ff.ctrl.high_dither_one <= 1'b1;
            st_ff.ctrl.high_dither_two <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata           = st_ff.rdata;
    assign self_test_err_count = st_ff.err_cnt;
    assign ctrl                = st_ff.ctrl;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    pass_blocks_a: assert property (
        st_ff.regs[vdcr_pkg::IDX_DP][vdcr_pkg::DP_PASS]
        |=> ctrl.pass_pixels && !ctrl.protect_ok && ctrl.packet_audio_blocked)
        else $error("pass-pixels did not block protection and packet audio");
    pv_polarity_a: assert property (
        reg_rd && reg_addr == vdcr_pkg::ADDR_DP |=> reg_rdata[5] == $past(pixel_valid_pol))
        else $error("pixel-valid polarity not reported");
    chan_b_ovr_a: assert property (
        reg_wr && reg_addr == vdcr_pkg::ADDR_DP && reg_wdata[3:0] == 4'h9
        |-> ##2 ctrl.ch_b_en)
        else $error("second channel override not applied");
    err_sat_a: assert property (
        st_ff.err_cnt == vdcr_pkg::ERR_MAX && st_ff.pins[vdcr_pkg::PIN_PDN] &&
        !(nxt_st.st_prev && !st_ff.st_prev) |=> st_ff.err_cnt == vdcr_pkg::ERR_MAX)
        else $error("error count left saturation");
    err_clear_a: assert property (
        !st_ff.pins[vdcr_pkg::PIN_PDN] |=> st_ff.err_cnt == vdcr_pkg::ERR_RST)
        else $error("error count not cleared on power-down");
    st_reg_a: assert property (
        reg_wr && reg_addr == vdcr_pkg::ADDR_BIST && reg_wdata[3:0] == 4'h1
        |-> ##2 ctrl.st_active)
        else $error("register self-test start not seen");
    scl_high_a: assert property (
        reg_wr && reg_addr == vdcr_pkg::ADDR_HI |-> ##2 ctrl.scl_high == $past(reg_wdata, 2))
        else $error("high time not taken");
    fc_block_a: assert property (
        st_ff.regs[vdcr_pkg::IDX_DP2][vdcr_pkg::DP2_BLOCK] &&
        !(reg_wr && reg_addr == vdcr_pkg::ADDR_DP2)
        |=> $stable(st_ff.regs[vdcr_pkg::IDX_DP2]))
        else $error("forward channel changed a blocked register");
    hi_dither_a: assert property (
        reg_wr && reg_addr == vdcr_pkg::ADDR_FRC && reg_wdata[vdcr_pkg::FRC_HI1]
        |-> ##2 !ctrl.high_dither_one)
        else $error("high dither sense not inverted");
    csum_a: assert property (
        line_checksum_fail && st_ff.regs[vdcr_pkg::IDX_RXM][vdcr_pkg::RXM_CSUM]
        |=> ctrl.checksum_fail)
        else $error("checksum failure not reported");
    unmapped_a: assert property (
        reg_rd && (reg_addr < vdcr_pkg::ADDR_BASE || reg_addr > vdcr_pkg::ADDR_AUD)
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    st_run_c: cover property (ctrl.st_active && fc_error ##1 st_ff.err_cnt != 8'h00);
    fc_load_c: cover property (fc_cfg_wr && !ctrl.fc_cfg_blocked);
    surround_c: cover property (ctrl.surround_en);

endmodule : vdcr_regs

// >>> testbench/tb_video_deserializer_config_regs.sv
// Self-checking bench for the deserializer configuration register bank.
`timescale 1ns/100ps
module tb_video_deserializer_config_regs;
    logic                 sys_clk, rst, reg_wr, reg_rd, fc_cfg_wr, fc_error;
    logic                 line_checksum_fail, pixel_valid_pol;
    logic                 inband_mode_valid, inband_surround;
    logic [7:0]           far_addr [3] = '{8'h21, 8'h2c, 8'hff};
    logic [7:0]           reg_addr, reg_wdata, reg_rdata, fc_cfg_data, self_test_err_count;
    logic [7:0]           err_exp, rd, mirror [10];
    logic [5:0]           strap_pins;
    vdcr_pkg::vdcr_ctrl_s ctrl;
    int                   num_errors = 0;
    int                   checks_done = 0;
    int                   seed = 63;
    int                   i;

    vdcr_host_model host_u (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    vdcr_regs dut_u (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fc_cfg_wr(fc_cfg_wr),
        .fc_cfg_data(fc_cfg_data), .strap_pins(strap_pins), .pixel_valid_pol(pixel_valid_pol),
        .fc_error(fc_error), .line_checksum_fail(line_checksum_fail),
        .inband_mode_valid(inband_mode_valid), .inband_surround(inband_surround),
        .self_test_err_count(self_test_err_count), .ctrl(ctrl));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_byte

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask : settle

    // Read view: live status bits overlay the stored byte.
    function automatic logic [7:0] exp_rd(input int k);
        logic [7:0] v;
        v = mirror[k];
        if (k == vdcr_pkg::IDX_DP) v[5] = pixel_valid_pol;
        if (k == vdcr_pkg::IDX_RXM) v[3:0] = {strap_pins[0], strap_pins[2:1], strap_pins[3]};
        if (k == vdcr_pkg::IDX_ERR) v = err_exp;
        return v;
    endfunction : exp_rd

    task automatic wr_reg(input int k, input logic [7:0] d);
        host_u.bus_write(vdcr_pkg::ADDR_BASE + 8'(k), d);
        mirror[k] = (mirror[k] & ~vdcr_pkg::REG_WMASK[k]) | (d & vdcr_pkg::REG_WMASK[k]);
    endtask : wr_reg

    task automatic rd_chk(input int k);
        host_u.bus_read(vdcr_pkg::ADDR_BASE + 8'(k), rd);
        chk_byte(rd, exp_rd(k), "register read");
    endtask : rd_chk

    task automatic chk_ctrl();
        logic [7:0] g, dp, d2, fr, au;
        logic       sr;
        dp = mirror[vdcr_pkg::IDX_DP];
        d2 = mirror[vdcr_pkg::IDX_DP2];
        fr = mirror[vdcr_pkg::IDX_FRC];
        au = mirror[vdcr_pkg::IDX_AUD];
        sr = (strap_pins[2] && inband_mode_valid) ? inband_surround : d2[0];
        settle(2);
        chk_byte(ctrl.scl_high, mirror[vdcr_pkg::IDX_HI], "high time");
        chk_byte(ctrl.scl_low, mirror[vdcr_pkg::IDX_LO], "low time");
        chk_byte(ctrl.slave_setup, mirror[vdcr_pkg::IDX_LO], "setup time");
        g = {ctrl.sync_timing, ctrl.line_sync_low, ctrl.frame_sync_low, ctrl.pixel_valid_low,
            ctrl.dither_stage_two, ctrl.dither_stage_one, ~ctrl.high_dither_two,
            ~ctrl.high_dither_one};
        chk_byte(g, fr, "dither timing");
        g = {ctrl.page, ctrl.white_balance_en, ctrl.lookup_table_reload, ctrl.pll_off,
            ctrl.sample_rising, ctrl.osc_sel};
        chk_byte(g, {mirror[vdcr_pkg::IDX_WB][7:4], au[7] & au[6], au[0],
            mirror[vdcr_pkg::IDX_BIST][2:1]}, "page audio osc");
        g = {ctrl.pass_pixels, ~ctrl.protect_ok, ctrl.packet_audio_blocked, ctrl.audio_regen,
            ctrl.color_18bit, ctrl.audio_fc_transport, ctrl.ch_b_en, ctrl.checksum_en};
        chk_byte(g, {dp[6], dp[6], dp[6], dp[4], dp[2], dp[1], dp[3] ? dp[0] : strap_pins[3],
            mirror[vdcr_pkg::IDX_RXM][7]}, "data path");
        g = {ctrl.fc_cfg_blocked, ctrl.aux_audio_en, ctrl.audio_disable, ctrl.surround_en, 4'h0};
        chk_byte(g, {d2[7], d2[3], d2[2], sr & ~dp[1], 4'h0}, "path two");
    endtask : chk_ctrl

    // Holds the error pulse high for n back-to-back cycles.
    task automatic err_burst(input int n);
        @(posedge sys_clk);
        #10;
        fc_error = 1'b1;
        repeat (n) @(posedge sys_clk);
        #10;
        fc_error = 1'b0;
        settle(2);
    endtask : err_burst

    initial begin
        #1_000_000;
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        {rst, fc_cfg_wr, fc_error, line_checksum_fail, pixel_valid_pol} = 5'h10;
        {inband_mode_valid, inband_surround} = 2'h0;
        fc_cfg_data = 8'h00;
        strap_pins = 6'h20;
        err_exp = 8'h00;
        for (i = 0; i < 10; i++) mirror[i] = vdcr_pkg::REG_RST[i];
        repeat (3) @(posedge sys_clk);
        #10;
        rst = 1'b0;
        for (i = 0; i < 10; i++) rd_chk(i);
        foreach (far_addr[j]) begin
            host_u.bus_write(far_addr[j], 8'h5a);
            host_u.bus_read(far_addr[j], rd);
            chk_byte(rd, 8'h00, "unmapped");
        end
        $display("test reset and unmapped done");
        // The repeater strap is forced so that the in-band surround override is reachable.
        strap_pins = {2'b10, 4'($random(seed)) | 4'h4};
        settle(6);
        rd_chk(vdcr_pkg::IDX_RXM);
        chk_byte({7'h0, ctrl.osc_low_rate}, {7'h0, strap_pins[0]}, "low rate");
        $display("test straps done");
        wr_reg(vdcr_pkg::IDX_DP, 8'h09);
        chk_ctrl();
        for (i = 0; i < 40; i++) begin
            host_u.gap = $unsigned($random(seed)) % 3;
            pixel_valid_pol = 1'($random(seed));
            {inband_mode_valid, inband_surround} = 2'($random(seed));
            wr_reg($unsigned($random(seed)) % 10, 8'($random(seed)));
            for (int k = 0; k < 10; k++) rd_chk(k);
            chk_ctrl();
        end
        host_u.gap = 0;
        $display("test random access done");
        wr_reg(vdcr_pkg::IDX_DP2, 8'h00);
        for (int j = 0; j < 2; j++) begin
            if (j == 1) wr_reg(vdcr_pkg::IDX_DP2, 8'h80);
            @(posedge sys_clk);
            #10;
            fc_cfg_wr = 1'b1;
            fc_cfg_data = (j == 0) ? 8'hff : 8'h0d;
            @(posedge sys_clk);
            #10;
            fc_cfg_wr = 1'b0;
            if (j == 0) mirror[vdcr_pkg::IDX_DP2] = vdcr_pkg::DP2_FC_MASK;
            rd_chk(vdcr_pkg::IDX_DP2);
        end
        $display("test forward channel done");
        for (int j = 0; j < 2; j++) begin
            wr_reg(vdcr_pkg::IDX_RXM, (j == 0) ? 8'h80 : 8'h00);
            @(posedge sys_clk);
            #10;
            line_checksum_fail = 1'b1;
            @(posedge sys_clk);
            #10;
            line_checksum_fail = 1'b0;
            chk_byte({7'h0, ctrl.checksum_fail}, (j == 0) ? 8'h01 : 8'h00, "checksum");
            settle(1);
            chk_byte({7'h0, ctrl.checksum_fail}, 8'h00, "checksum pulse");
        end
        $display("test checksum done");
        wr_reg(vdcr_pkg::IDX_BIST, 8'h00);
        wr_reg(vdcr_pkg::IDX_BIST, 8'h01);
        err_exp = 8'h00;
        settle(3);
        i = 5 + $unsigned($random(seed)) % 20;
        err_burst(i);
        wr_reg(vdcr_pkg::IDX_BIST, 8'h00);
        err_burst(3);
        err_exp = 8'(i);
        rd_chk(vdcr_pkg::IDX_ERR);
        chk_byte(self_test_err_count, err_exp, "count port");
        wr_reg(vdcr_pkg::IDX_BIST, 8'h01);
        err_exp = 8'h00;
        settle(3);
        rd_chk(vdcr_pkg::IDX_ERR);
        err_burst(300);
        wr_reg(vdcr_pkg::IDX_BIST, 8'h00);
        err_exp = 8'hff;
        rd_chk(vdcr_pkg::IDX_ERR);
        strap_pins[5] = 1'b0;
        settle(6);
        err_exp = 8'h00;
        rd_chk(vdcr_pkg::IDX_ERR);
        strap_pins[5] = 1'b1;
        wr_reg(vdcr_pkg::IDX_BIST, 8'h08);
        strap_pins[4] = 1'b1;
        settle(6);
        chk_byte({7'h0, ctrl.st_active}, 8'h01, "pin start");
        strap_pins[4] = 1'b0;
        wr_reg(vdcr_pkg::IDX_BIST, 8'h09);
        settle(6);
        chk_byte({7'h0, ctrl.st_active}, 8'h00, "register ignored");
        $display("test self test done");
        stop_test();
    end
endmodule : tb_video_deserializer_config_regs

// >>> testbench/vdcr_host_model.sv
// Host model that issues single-byte register accesses on the strobe port.
`timescale 1ns/100ps
module vdcr_host_model (
    input  wire logic       sys_clk,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    int gap = 0;

    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Released lines carry the inverse of the last value so a stale bus never looks valid.
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        #10;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #10;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : bus_write

    task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        #10;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk);
        #10;
        d = reg_rdata;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask : bus_read
endmodule : vdcr_host_model
